// File: rtl/clkgen_regs.svh
`ifndef CLKGEN_REGS_SVH
`define CLKGEN_REGS_SVH

// ==========================================================================
// Register offsets (byte addresses on the APB side)
`define OFS_OSC_CTRL    8'h00
`define OFS_FREQ_METER  8'h04
`define OFS_SYNTH_CFG   8'h08
`define OFS_MCK_CFG     8'h0c
`define OFS_PWR_STAT    8'h10
`define OFS_IRQ_MASK    8'h14
`define OFS_CPU_IDLE    8'h18

// ==========================================================================
// Field positions
`define OSC_EN_BIT      0
`define OSC_BYP_BIT     1
`define OSC_CNT_LSB     8
`define OSC_CNT_MSB     15
`define FREQ_CNT_MSB    15
`define FREQ_DONE_BIT   16
`define PLL_DIV_LSB     0
`define PLL_DIV_MSB     7
`define PLL_SETTLE_LSB  8
`define PLL_SETTLE_MSB  13
`define PLL_GAIN_LSB    16
`define PLL_GAIN_MSB    26
`define MCK_SRC_LSB     0
`define MCK_SRC_MSB     1
`define MCK_MCK_POWER2_DIVISOR_LSB    2
`define MCK_MCK_POWER2_DIVISOR_MSB    4
`define STAT_OSC_BIT    0
`define STAT_LOCK_BIT   2
`define STAT_MCK_BIT    3
`define STAT_CPU_BIT    7
`define STAT_MSB        7
`define IDLE_BIT        0

// ==========================================================================
// Codes, reset values and counts
`define SRC_SLOW        2'h0
`define SRC_XTAL        2'h1
`define SRC_SYNTH       2'h2
`define MCK_RST_SRC     2'h0
`define MCK_RST_MCK_POWER2_DIVISOR    3'h0
`define MCK_MCK_POWER2_DIVISOR_MAX    3'h6
`define MASK_RST        8'h00
`define OSC_TICK_LAST   3'h7
`define FREQ_LAST_FALL  4'hf

`endif

// File: rtl/clkgen_pkg.sv
package clkgen_pkg;

  // ========================================================================
  // Configuration carriers
  typedef struct packed {
    logic       enable;
    logic       bypass;
    logic [7:0] count;
  } osc_cfg_t;

  typedef struct packed {
    logic [10:0] gain;
    logic [5:0]  settle;
    logic [7:0]  prescale;
  } pll_cfg_t;

  typedef struct packed {
    logic [1:0] src;
    logic [2:0] mck_power2_divisor;
  } mck_cfg_t;

  // ========================================================================
  // State machines
  typedef enum logic [1:0] {FM_IDLE, FM_ARM, FM_COUNT, FM_DONE} freq_state_t;
  typedef enum logic [1:0] {MK_RUN, MK_DRAIN, MK_WAIT_NEW} mck_state_t;

endpackage

// File: rtl/pin_sync.sv
`timescale 1ns/1ps

// ==========================================================================
// Two-flop synchroniser; only the second stage leaves the module
module pin_sync (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic pin_i,
  output logic      level_o
);

  logic meta_q;

  // First stage read only by the second
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_q  <= 1'b0;
      level_o <= 1'b0;
    end else begin
      meta_q  <= pin_i;
      level_o <= meta_q;
    end
  end

endmodule

// File: rtl/mck_prescaler.sv
`timescale 1ns/1ps
`include "clkgen_regs.svh"

// ==========================================================================
// Glitch-free source switch and power-of-two prescaler for the master clock
module mck_prescaler (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic [2:0]          src_lvl_i,
  input  wire clkgen_pkg::mck_cfg_t cfg_i,
  input  wire logic                cfg_wr_i,
  output logic                     mck_o,
  output logic                     settled_o
);

  clkgen_pkg::mck_state_t state_q;
  clkgen_pkg::mck_cfg_t   act_q;
  clkgen_pkg::mck_cfg_t   pend_q;
  logic [5:0]             div_q;
  logic                   src_prev_q;
  logic                   src;
  logic                   src_rise;

  // Pick one of the three generator clocks; unused code falls back to slow
  function automatic logic src_pick(input logic [2:0] lvl, input logic [1:0] sel);
    unique case (sel)
      `SRC_XTAL:  src_pick = lvl[1];
      `SRC_SYNTH: src_pick = lvl[2];
      default:    src_pick = lvl[0];
    endcase
  endfunction

  // Divided level: bit mck_power2_divisor-1 of the edge counter, or the source itself
  function automatic logic div_tap(input logic s, input logic [5:0] d, input logic [2:0] p);
    // Code 7 would tap past the counter; it is held at the /64 tap instead
    if (p == 3'h0)                div_tap = s;
    else if (p > `MCK_MCK_POWER2_DIVISOR_MAX)   div_tap = d[`MCK_MCK_POWER2_DIVISOR_MAX - 3'h1];
    else                          div_tap = d[p - 3'h1];
  endfunction

  assign src      = src_pick(src_lvl_i, act_q.src);
  assign src_rise = src & ~src_prev_q;

  // Edge counter of the active source
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      src_prev_q <= 1'b0;
      div_q      <= 6'h00;
    end else begin
      src_prev_q <= src;
      if (state_q == clkgen_pkg::MK_WAIT_NEW) begin
        div_q <= 6'h00;
      end else if (src_rise) begin
        div_q <= div_q + 6'h01;
      end
    end
  end

  // Old clock runs until its low phase, then held low until new source rises
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q   <= clkgen_pkg::MK_RUN;
      act_q     <= '{src: `MCK_RST_SRC, mck_power2_divisor: `MCK_RST_MCK_POWER2_DIVISOR};
      pend_q    <= '{src: `MCK_RST_SRC, mck_power2_divisor: `MCK_RST_MCK_POWER2_DIVISOR};
      mck_o     <= 1'b0;
      settled_o <= 1'b1;
    end else begin
      if (cfg_wr_i) begin
        pend_q    <= cfg_i;
        settled_o <= 1'b0;
        state_q   <= clkgen_pkg::MK_DRAIN;
      end
      unique case (state_q)
        clkgen_pkg::MK_RUN: begin
          mck_o <= div_tap(src, div_q, act_q.mck_power2_divisor);
        end
        clkgen_pkg::MK_DRAIN: begin
          // Avoid a runt high pulse: wait for the old clock to go low
          if (mck_o) begin
            mck_o <= div_tap(src, div_q, act_q.mck_power2_divisor);
          end else if (!cfg_wr_i) begin
            act_q   <= pend_q;
            state_q <= clkgen_pkg::MK_WAIT_NEW;
          end
        end
        clkgen_pkg::MK_WAIT_NEW: begin
          mck_o <= 1'b0;
          if (src_rise && !cfg_wr_i) begin
            state_q   <= clkgen_pkg::MK_RUN;
            settled_o <= 1'b1;
          end
        end
      endcase
    end
  end

endmodule

// File: rtl/clock_gen_master_clock_ctrl.sv
`timescale 1ns/1ps
`include "clkgen_regs.svh"

module clock_gen_master_clock_ctrl (
  input  wire logic        CLK_I,
  input  wire logic        SYS_RST_I,
  // APB slave
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic [31:0]      PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  // Generator clocks arriving as pins
  input  wire logic        SLOW_CLK_I,
  input  wire logic        CRYSTAL_CLK_I,
  input  wire logic        SYNTH_CLK_I,
  // Enabled interrupt pending: wakes the processor clock
  input  wire logic        WAKE_I,
  // Analog controls
  output logic             OSC_EN_O,
  output logic             OSC_BYPASS_O,
  output logic [7:0]       PLL_DIV_O,
  output logic [10:0]      PLL_GAIN_O,
  output logic             PLL_EN_O,
  // Derived clocks and interrupt
  output logic             MCK_O,
  output logic             CPU_CLK_O,
  output logic             MCK_SETTLED_O,
  output logic             IRQ_O
);

  // ========================================================================
  // Declarations
  clkgen_pkg::osc_cfg_t    osc_q;
  clkgen_pkg::pll_cfg_t    pll_q;
  clkgen_pkg::mck_cfg_t    mck_cfg;
  clkgen_pkg::freq_state_t fm_state_q;
  logic               slow_s;
  logic               xtal_s;
  logic               synth_s;
  logic               slow_prev_q;
  logic               xtal_prev_q;
  logic               slow_rise;
  logic               slow_fall;
  logic               xtal_rise;
  logic               wr_en;
  logic               rd_setup;
  logic               wr_osc;
  logic               wr_pll;
  logic               wr_mck;
  logic               wr_idle;
  logic               stable_q;
  logic [7:0]         osc_cnt_q;
  logic [2:0]         osc_tick_q;
  logic [15:0]        freq_cnt_q;
  logic [3:0]         fall_cnt_q;
  logic               freq_done_q;
  logic               lock_q;
  logic [5:0]         lock_cnt_q;
  logic               pll_on;
  logic               synth_gated;
  logic               cpu_en_q;
  logic               mck_lvl;
  logic               mck_settled;
  logic [`STAT_MSB:0] mask_q;
  logic [`STAT_MSB:0] status;

  // ========================================================================
  // Address decode
  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a == `OFS_OSC_CTRL)  || (a == `OFS_FREQ_METER) ||
                  (a == `OFS_SYNTH_CFG) || (a == `OFS_MCK_CFG)    ||
                  (a == `OFS_PWR_STAT)  || (a == `OFS_IRQ_MASK)   ||
                  (a == `OFS_CPU_IDLE);
  endfunction

  function automatic logic wr_hit(input logic w, input logic [7:0] a, input logic [7:0] ofs);
    wr_hit = w && (a == ofs);
  endfunction

  // ========================================================================
  // Pin synchronisers; slow clock is sampled, never gated
  pin_sync u_sync_slow (
    .clk_i   (CLK_I),
    .rst_i   (SYS_RST_I),
    .pin_i   (SLOW_CLK_I),
    .level_o (slow_s)
  );

  pin_sync u_sync_xtal (
    .clk_i   (CLK_I),
    .rst_i   (SYS_RST_I),
    .pin_i   (CRYSTAL_CLK_I),
    .level_o (xtal_s)
  );

  pin_sync u_sync_synth (
    .clk_i   (CLK_I),
    .rst_i   (SYS_RST_I),
    .pin_i   (SYNTH_CLK_I),
    .level_o (synth_s)
  );

  // Edge detectors look only at the second synchroniser stage
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      slow_prev_q <= 1'b0;
      xtal_prev_q <= 1'b0;
    end else begin
      slow_prev_q <= slow_s;
      xtal_prev_q <= xtal_s;
    end
  end

  assign slow_rise = slow_s & ~slow_prev_q;
  assign slow_fall = ~slow_s & slow_prev_q;
  assign xtal_rise = xtal_s & ~xtal_prev_q;

  // ========================================================================
  // APB strobes; zero wait states
  assign wr_en    = PSEL_I & PENABLE_I & PWRITE_I;
  assign rd_setup = PSEL_I & ~PENABLE_I & ~PWRITE_I;
  assign wr_osc   = wr_hit(wr_en, PADDR_I, `OFS_OSC_CTRL);
  assign wr_pll   = wr_hit(wr_en, PADDR_I, `OFS_SYNTH_CFG);
  assign wr_mck   = wr_hit(wr_en, PADDR_I, `OFS_MCK_CFG);
  assign wr_idle  = wr_hit(wr_en, PADDR_I, `OFS_CPU_IDLE);

  assign PREADY_O  = 1'b1;
  assign PSLVERR_O = PSEL_I & PENABLE_I & ~addr_mapped(PADDR_I);

  // ========================================================================
  // Oscillator control register
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      osc_q <= '0;
    end else if (wr_osc) begin
      osc_q.enable <= PWDATA_I[`OSC_EN_BIT];
      osc_q.bypass <= PWDATA_I[`OSC_BYP_BIT];
      osc_q.count  <= PWDATA_I[`OSC_CNT_MSB:`OSC_CNT_LSB];
    end
  end

  // Bypass keeps the amplifier off even if enable is wrongly set
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      OSC_EN_O     <= 1'b0;
      OSC_BYPASS_O <= 1'b0;
    end else begin
      OSC_EN_O     <= osc_q.enable & ~osc_q.bypass;
      OSC_BYPASS_O <= osc_q.bypass;
    end
  end

  // ========================================================================
  // Start-up counter: one step per eight slow rising edges
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      stable_q   <= 1'b0;
      osc_cnt_q  <= 8'h00;
      osc_tick_q <= 3'h0;
    end else if (wr_osc) begin
      stable_q   <= 1'b0;
      osc_cnt_q  <= PWDATA_I[`OSC_CNT_MSB:`OSC_CNT_LSB];
      osc_tick_q <= 3'h0;
    end else if (!osc_q.enable) begin
      stable_q <= 1'b0;
    end else if (osc_cnt_q == 8'h00) begin
      stable_q <= 1'b1;
    end else if (slow_rise) begin
      osc_tick_q <= osc_tick_q + 3'h1;
      if (osc_tick_q == `OSC_TICK_LAST) begin
        osc_cnt_q <= osc_cnt_q - 8'h01;
      end
    end
  end

  // ========================================================================
  // Crystal frequency meter from a slow rising edge to the sixteenth slow falling edge
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      fm_state_q  <= clkgen_pkg::FM_IDLE;
      freq_cnt_q  <= 16'h0000;
      fall_cnt_q  <= 4'h0;
      freq_done_q <= 1'b0;
    end else if (!stable_q) begin
      fm_state_q  <= clkgen_pkg::FM_IDLE;
      freq_done_q <= 1'b0;
    end else begin
      unique case (fm_state_q)
        clkgen_pkg::FM_IDLE: begin
          freq_cnt_q <= 16'h0000;
          fall_cnt_q <= 4'h0;
          fm_state_q <= clkgen_pkg::FM_ARM;
        end
        clkgen_pkg::FM_ARM: begin
          if (slow_rise) begin
            fm_state_q <= clkgen_pkg::FM_COUNT;
          end
        end
        clkgen_pkg::FM_COUNT: begin
          if (xtal_rise) begin
            freq_cnt_q <= freq_cnt_q + 16'h0001;
          end
          if (slow_fall) begin
            fall_cnt_q <= fall_cnt_q + 4'h1;
            if (fall_cnt_q == `FREQ_LAST_FALL) begin
              fm_state_q  <= clkgen_pkg::FM_DONE;
              freq_done_q <= 1'b1;
            end
          end
        end
        clkgen_pkg::FM_DONE: begin
          freq_done_q <= 1'b1;
        end
      endcase
    end
  end

  // ========================================================================
  // PLL configuration; any write restarts the lock wait
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      pll_q <= '0;
    end else if (wr_pll) begin
      pll_q.prescale <= PWDATA_I[`PLL_DIV_MSB:`PLL_DIV_LSB];
      pll_q.settle   <= PWDATA_I[`PLL_SETTLE_MSB:`PLL_SETTLE_LSB];
      pll_q.gain     <= PWDATA_I[`PLL_GAIN_MSB:`PLL_GAIN_LSB];
    end
  end

  // Zero gain powers the loop down; zero divider starves it
  assign pll_on      = (pll_q.gain != 11'h000) && (pll_q.prescale != 8'h00);
  assign synth_gated = synth_s & pll_on;

  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      PLL_DIV_O  <= 8'h00;
      PLL_GAIN_O <= 11'h000;
      PLL_EN_O   <= 1'b0;
    end else begin
      PLL_DIV_O  <= pll_q.prescale;
      PLL_GAIN_O <= pll_q.gain;
      PLL_EN_O   <= pll_on;
    end
  end

  // Lock counter steps once per slow rising edge
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      lock_q     <= 1'b0;
      lock_cnt_q <= 6'h00;
    end else if (wr_pll) begin
      lock_q     <= 1'b0;
      lock_cnt_q <= PWDATA_I[`PLL_SETTLE_MSB:`PLL_SETTLE_LSB];
    end else if (!pll_on) begin
      lock_q <= 1'b0;
    end else if (lock_cnt_q == 6'h00) begin
      lock_q <= 1'b1;
    end else if (slow_rise) begin
      lock_cnt_q <= lock_cnt_q - 6'h01;
    end
  end

  // ========================================================================
  // Master clock selection and prescaling
  assign mck_cfg.src  = PWDATA_I[`MCK_SRC_MSB:`MCK_SRC_LSB];
  assign mck_cfg.mck_power2_divisor = PWDATA_I[`MCK_MCK_POWER2_DIVISOR_MSB:`MCK_MCK_POWER2_DIVISOR_LSB];

  mck_prescaler u_mck (
    .clk_i     (CLK_I),
    .rst_i     (SYS_RST_I),
    .src_lvl_i ({synth_gated, xtal_s, slow_s}),
    .cfg_i     (mck_cfg),
    .cfg_wr_i  (wr_mck),
    .mck_o     (mck_lvl),
    .settled_o (mck_settled)
  );

  assign MCK_O         = mck_lvl;
  assign MCK_SETTLED_O = mck_settled;

  // ========================================================================
  // Processor clock: idle write stops it, wake wins over a same-cycle idle
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      cpu_en_q <= 1'b1;
    end else if (WAKE_I) begin
      cpu_en_q <= 1'b1;
    end else if (wr_idle && PWDATA_I[`IDLE_BIT]) begin
      cpu_en_q <= 1'b0;
    end
  end

  // Registered gate; lags the master clock by one bus cycle
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      CPU_CLK_O <= 1'b0;
    end else begin
      CPU_CLK_O <= mck_lvl & cpu_en_q;
    end
  end

  // ========================================================================
  // Status, mask and interrupt
  always_comb begin
    status                 = '0;
    status[`STAT_OSC_BIT]  = stable_q;
    status[`STAT_LOCK_BIT] = lock_q;
    status[`STAT_MCK_BIT]  = mck_settled;
    status[`STAT_CPU_BIT]  = cpu_en_q;
  end

  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      mask_q <= `MASK_RST;
    end else if (wr_hit(wr_en, PADDR_I, `OFS_IRQ_MASK)) begin
      mask_q <= PWDATA_I[`STAT_MSB:0];
    end
  end

  // Level line: follows the flags, no latching of its own
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      IRQ_O <= 1'b0;
    end else begin
      IRQ_O <= |(status & mask_q);
    end
  end

  // ========================================================================
  // Read data captured in the setup phase
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      PRDATA_O <= 32'h0000_0000;
    end else if (rd_setup) begin
      PRDATA_O <= 32'h0000_0000;
      unique case (PADDR_I)
        `OFS_OSC_CTRL: begin
          PRDATA_O[`OSC_EN_BIT]                <= osc_q.enable;
          PRDATA_O[`OSC_BYP_BIT]               <= osc_q.bypass;
          PRDATA_O[`OSC_CNT_MSB:`OSC_CNT_LSB]  <= osc_q.count;
        end
        `OFS_FREQ_METER: begin
          PRDATA_O[`FREQ_CNT_MSB:0]   <= freq_cnt_q;
          PRDATA_O[`FREQ_DONE_BIT]    <= freq_done_q;
        end
        `OFS_SYNTH_CFG: begin
          PRDATA_O[`PLL_DIV_MSB:`PLL_DIV_LSB]       <= pll_q.prescale;
          PRDATA_O[`PLL_SETTLE_MSB:`PLL_SETTLE_LSB] <= pll_q.settle;
          PRDATA_O[`PLL_GAIN_MSB:`PLL_GAIN_LSB]     <= pll_q.gain;
        end
        `OFS_MCK_CFG: begin
          PRDATA_O[`MCK_SRC_MSB:`MCK_SRC_LSB]   <= u_mck.act_q.src;
          PRDATA_O[`MCK_MCK_POWER2_DIVISOR_MSB:`MCK_MCK_POWER2_DIVISOR_LSB] <= u_mck.act_q.mck_power2_divisor;
        end
        `OFS_PWR_STAT: PRDATA_O[`STAT_MSB:0] <= status;
        `OFS_IRQ_MASK: PRDATA_O[`STAT_MSB:0] <= mask_q;
        default:       PRDATA_O <= 32'h0000_0000;
      endcase
    end
  end

endmodule

// File: bench/mck_ctrl_props.sv
`timescale 1ns/1ps

// ====
// Port-level checks on the clock control block
module mck_ctrl_props (
  input wire logic        CLK_I,
  input wire logic        SYS_RST_I,
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic        PWRITE_I,
  input wire logic [7:0]  PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic        WAKE_I,
  input wire logic        OSC_EN_O,
  input wire logic [7:0]  PLL_DIV_O,
  input wire logic [10:0] PLL_GAIN_O,
  input wire logic        PLL_EN_O,
  input wire logic        MCK_O,
  input wire logic        CPU_CLK_O,
  input wire logic        MCK_SETTLED_O
);
  logic        wr;
  logic [31:0] osc_q;
  logic [31:0] pll_q;

  // Completed write; data kept since the bus releases it at once
  assign wr = PSEL_I && PENABLE_I && PWRITE_I;
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      osc_q <= 32'h0;
      pll_q <= 32'h0;
    end else if (wr) begin
      osc_q <= (PADDR_I == 8'h00) ? PWDATA_I : osc_q;
      pll_q <= (PADDR_I == 8'h08) ? PWDATA_I : pll_q;
    end
  end

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);

  // ====
  // Properties
  property p_reset_state;
    $fell(SYS_RST_I) |-> !OSC_EN_O && PLL_DIV_O == 8'h00 && MCK_SETTLED_O;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("bad state after reset");
  property p_pll_en;
    PLL_EN_O == (PLL_GAIN_O != 11'h000 && PLL_DIV_O != 8'h00);
  endproperty
  a_pll_en: assert property (p_pll_en) else $error("pll enable wrong");
  property p_pll_cfg;
    wr && PADDR_I == 8'h08 |-> ##[1:2] PLL_DIV_O == pll_q[7:0] && PLL_GAIN_O == pll_q[26:16];
  endproperty
  a_pll_cfg: assert property (p_pll_cfg) else $error("pll factors wrong");
  property p_osc_ctrl;
    wr && PADDR_I == 8'h00 |-> ##[1:2] OSC_EN_O == (osc_q[0] && !osc_q[1]);
  endproperty
  a_osc_ctrl: assert property (p_osc_ctrl) else $error("osc enable wrong");
  property p_mck_clear;
    wr && PADDR_I == 8'h0c |-> ##[1:2] !MCK_SETTLED_O;
  endproperty
  a_mck_clear: assert property (p_mck_clear) else $error("settled not cleared");
  property p_mck_bound;
    $fell(MCK_SETTLED_O) |-> ##[1:1000] MCK_SETTLED_O;
  endproperty
  a_mck_bound: assert property (p_mck_bound) else $error("settled never returns");
  property p_cpu_gate;
    CPU_CLK_O |-> $past(MCK_O);
  endproperty
  a_cpu_gate: assert property (p_cpu_gate) else $error("cpu clock not from mck");
  property p_idle_stop;
    wr && PADDR_I == 8'h18 && PWDATA_I[0] && !WAKE_I |-> ##2 (!CPU_CLK_O) [*8];
  endproperty
  a_idle_stop: assert property (p_idle_stop) else $error("cpu clock runs in idle");
  c_mck_wr: cover property (wr && PADDR_I == 8'h0c);
  c_pll_on: cover property ($rose(PLL_EN_O));
  c_settled: cover property ($rose(MCK_SETTLED_O));
endmodule

bind clock_gen_master_clock_ctrl mck_ctrl_props mck_ctrl_props_i (
  .CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
  .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .WAKE_I(WAKE_I),
  .OSC_EN_O(OSC_EN_O), .PLL_DIV_O(PLL_DIV_O), .PLL_GAIN_O(PLL_GAIN_O), .PLL_EN_O(PLL_EN_O),
  .MCK_O(MCK_O), .CPU_CLK_O(CPU_CLK_O), .MCK_SETTLED_O(MCK_SETTLED_O));

// File: bench/clock_gen_master_clock_ctrl_bench.sv
`timescale 1ns/1ps

module clock_gen_master_clock_ctrl_bench;
  logic        clk, rst, psel, pen, pwr, slow, xtal, syn, wake, prdy, perr, err;
  logic        osc_en, pll_en, mck, cpu, setl, irq, byp;
  logic [7:0]  padr, pdiv;
  logic [10:0] pgain;
  logic [31:0] pwd, prd, rd;
  // Code 3 is reserved and must behave as the slow clock
  logic [4:0]  cfg [6] = '{5'h18, 5'h08, 5'h05, 5'h06, 5'h07, 5'h00};
  int          per [6] = '{640, 40, 10, 15, 20, 10};
  int          num_errors, samples_checked, cyc, p, q, i;

  clock_gen_master_clock_ctrl clock_gen_master_clock_ctrl_i (
    .CLK_I(clk), .SYS_RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
    .PADDR_I(padr), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(prdy), .PSLVERR_O(perr),
    .SLOW_CLK_I(slow), .CRYSTAL_CLK_I(xtal), .SYNTH_CLK_I(syn), .WAKE_I(wake),
    .OSC_EN_O(osc_en), .OSC_BYPASS_O(byp), .PLL_DIV_O(pdiv), .PLL_GAIN_O(pgain),
    .PLL_EN_O(pll_en), .MCK_O(mck), .CPU_CLK_O(cpu), .MCK_SETTLED_O(setl), .IRQ_O(irq));

  // ====
  // Clocks: slow 10, crystal 5, synth 7.5 bus cycles; offsets keep edges off clk
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    slow = 1'b0;
    forever #40 slow = ~slow;
  end
  initial begin
    xtal = 1'b0;
    #1;
    forever #20 xtal = ~xtal;
  end
  initial begin
    syn = 1'b0;
    #1;
    forever #30 syn = ~syn;
  end
  // Free cycle count for period checks
  always @(posedge clk) cyc <= cyc + 1;
  // Whole run is a few thousand cycles; this leaves wide margin
  initial begin
    #100000;
    num_errors++;
    report_and_stop;
  end

  // ====
  // Tasks
  task chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, s, e);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pen  <= 1'b0;
    pwr  <= w;
    padr <= a;
    pwd  <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (prdy !== 1'b1);
    rd  = prd;
    err = perr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask
  // Bounded poll of one register bit
  task poll(input logic [7:0] a, input int b);
    int n;
    n = 0;
    do begin
      apb(1'b0, a, 32'h0);
      n++;
    end while (rd[b] !== 1'b1 && n < 400);
    chk(32'(rd[b]), 32'h1);
  endtask
  task w3;
    repeat (3) @(posedge clk);
  endtask
  task rise;
    logic m;
    m = mck;
    @(posedge clk);
    while (!(mck === 1'b1 && m === 1'b0)) begin
      m = mck;
      @(posedge clk);
    end
  endtask
  task report_and_stop;
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ====
  // Main sequence
  initial begin
    {rst, psel, pen, pwr, wake} = 5'h10;
    padr = 8'h00;
    pwd  = 32'h0;
    cyc  = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0);
    chk(32'(osc_en), 32'h0);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h0c, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk(32'(err), 32'h1);
    // Oscillator start-up: count 1 means eight slow periods
    apb(1'b1, 8'h14, 32'h1);
    apb(1'b1, 8'h00, 32'h101);
    w3;
    chk(32'(osc_en), 32'h1);
    repeat (40) @(posedge clk);
    apb(1'b0, 8'h10, 32'h0);
    chk(32'(rd[0]), 32'h0);
    poll(8'h10, 0);
    chk(32'(irq), 32'h1);
    apb(1'b1, 8'h14, 32'h0);
    w3;
    chk(32'(irq), 32'h0);
    poll(8'h04, 16);
    chk(32'(rd[15:0] >= 16'd31 && rd[15:0] <= 16'd33), 32'h1);
    // Synth: gain 4, settle 3, divide 1
    apb(1'b1, 8'h08, 32'h0004_0301);
    w3;
    chk(32'(pll_en), 32'h1);
    chk({pgain, 13'h0, pdiv}, {11'h4, 13'h0, 8'h1});
    apb(1'b0, 8'h10, 32'h0);
    chk(32'(rd[2]), 32'h0);
    poll(8'h10, 2);
    apb(1'b1, 8'h08, 32'h0000_0301);
    w3;
    chk(32'(pll_en), 32'h0);
    apb(1'b1, 8'h08, 32'h0004_0300);
    w3;
    chk(32'(pll_en), 32'h0);
    apb(1'b1, 8'h08, 32'h0004_0301);
    poll(8'h10, 2);
    // Master clock: period is source period shifted by the log2 divisor
    for (i = 0; i < 6; i++) begin
      apb(1'b1, 8'h0c, 32'(cfg[i]));
      repeat (2) @(posedge clk);
      chk(32'(setl), 32'h0);
      poll(8'h10, 3);
      apb(1'b0, 8'h0c, 32'h0);
      chk(rd, 32'(cfg[i]));
      rise;
      p = cyc;
      rise;
      chk(32'(cyc - p), 32'(per[i]));
    end
    // Idle stops the processor clock only
    apb(1'b1, 8'h18, 32'h1);
    w3;
    p = 0;
    q = 0;
    repeat (40) begin
      @(posedge clk);
      p += cpu;
      q += mck;
    end
    chk(32'(p), 32'h0);
    chk(32'(q), 32'd20);
    wake <= 1'b1;
    w3;
    p = 0;
    repeat (40) begin
      @(posedge clk);
      p += cpu;
    end
    chk(32'(p), 32'd20);
    wake <= 1'b0;
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk(32'(rd[0]), 32'h0);
    // External clock: bypass set keeps the amplifier off even with enable
    apb(1'b1, 8'h00, 32'h3);
    w3;
    chk(32'({osc_en, byp}), 32'h1);
    report_and_stop;
  end
endmodule
